// *** pkg/adhp_pkg.sv ***
package adhp_pkg;

    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    // Host divider: half a link clock period in system clocks.
    // It must cover both ends' synchroniser delay, or the host samples an answer too early.
    localparam int HALF_PERIOD_NS = 200;
    localparam int CLK_PERIOD_NS = 25;
    localparam int HALF_CYC = HALF_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_CNT = 8'(HALF_CYC - 1);
    // Strap levels that select the serial host mode.
    localparam logic STRAP_OE_N = 1'b0;
    localparam logic STRAP_WR_N = 1'b1;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_WRITE = 5'b00100,
        ST_READ = 5'b01000,
        ST_SKIP = 5'b10000
    } adhp_dev_st_t;

endpackage : adhp_pkg

// *** pkg/adhp_if.sv ***
`timescale 1ns/1ps
interface adhp_if;
    logic serial_ctrl_clock;
    logic sda_dev_o;
    logic sda_dev_oe;
    logic sda_host_o;
    logic sda_host_oe;
    logic req_oe;
    logic serial_ctrl_data_io;
    logic host_data_request_n;
    logic mem_output_enable_strobe_n;
    logic mem_write_strobe_n;

    // Open-drain resolution: any enabled driver with a low output pulls low.
    assign serial_ctrl_data_io = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
    assign host_data_request_n = !req_oe;

    modport device (
        input serial_ctrl_clock, serial_ctrl_data_io, mem_output_enable_strobe_n,
        input mem_write_strobe_n,
        output sda_dev_o, sda_dev_oe, req_oe
    );
    modport host (
        input serial_ctrl_data_io, host_data_request_n,
        output serial_ctrl_clock, sda_host_o, sda_host_oe,
        output mem_output_enable_strobe_n, mem_write_strobe_n
    );
endinterface : adhp_if

// *** logic/adhp_fifo.sv ***
`timescale 1ns/1ps
module adhp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Fill side.
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    // Drain side.
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic wr;
    logic rd;
    logic [AW:0] cnt_nxt;
    logic in_ready_r;

    assign IN_READY = in_ready_r;
    assign cnt_nxt = cnt_r + (AW+1)'(wr) - (AW+1)'(rd);
    assign OUT_VALID = (cnt_r != '0);
    assign OUT_DATA = mem_r[rp_r];
    assign wr = IN_VALID && IN_READY;
    assign rd = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (wr) begin
            mem_r[wp_r] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b1;
        end else begin
            if (wr) begin
                wp_r <= wp_r + 1'b1;
            end
            if (rd) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            in_ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule : adhp_fifo

// *** logic/adhp_device.sv ***
`timescale 1ns/1ps
module adhp_device
    import adhp_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Link.
    adhp_if.device LINK,
    // Address configuration.
    input wire logic ADDR_CHECK_EN,
    input wire logic ADDR_LOAD,
    input wire logic [ADDR_W-1:0] ADDR_NEW,
    // Outgoing bytes from the core.
    input wire logic TX_VALID,
    output logic TX_READY,
    input wire logic [DATA_W-1:0] TX_DATA,
    // Incoming bytes to the core.
    output logic RX_VALID,
    output logic [DATA_W-1:0] RX_DATA,
    // Status.
    output logic SERIAL_MODE,
    output logic [ADDR_W-1:0] SLAVE_ADDR
);
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic oe_s1_r, oe_s2_r, wr_s1_r, wr_s2_r;
    logic scl_rise, scl_fall, start_c, stop_c;
    adhp_dev_st_t st_r;
    logic [3:0] bit_r;
    logic [DATA_W-1:0] sh_r;
    logic rnw_r;
    logic ack_drv_r;
    logic rd_drv_r;
    logic [DATA_W-1:0] out_r;
    logic out_has_r;
    logic fifo_v;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_d;
    logic strap_done_r;
    logic [1:0] strap_wait_r;
    logic [DATA_W-1:0] rx_byte;
    logic at_ack;

    // Outgoing data buffer.
    adhp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .CLK(CLK), .RSTN(RSTN),
        .IN_VALID(TX_VALID), .IN_READY(TX_READY), .IN_DATA(TX_DATA),
        .OUT_VALID(fifo_v), .OUT_READY(fifo_pop), .OUT_DATA(fifo_d)
    );

    // ----------------------------------------
    // Pin synchronisers and edge detection.
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            scl_s1_r <= 1'b1; scl_s2_r <= 1'b1; scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1; sda_s2_r <= 1'b1; sda_d_r <= 1'b1;
            oe_s1_r <= 1'b1; oe_s2_r <= 1'b1; wr_s1_r <= 1'b1; wr_s2_r <= 1'b1;
        end else begin
            scl_s1_r <= LINK.serial_ctrl_clock; scl_s2_r <= scl_s1_r; scl_d_r <= scl_s2_r;
            sda_s1_r <= LINK.serial_ctrl_data_io; sda_s2_r <= sda_s1_r; sda_d_r <= sda_s2_r;
            oe_s1_r <= LINK.mem_output_enable_strobe_n; oe_s2_r <= oe_s1_r;
            wr_s1_r <= LINK.mem_write_strobe_n; wr_s2_r <= wr_s1_r;
        end
    end

    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    assign start_c = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
    assign stop_c = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
    assign rx_byte = {sh_r[DATA_W-2:0], sda_s2_r};
    assign at_ack = (bit_r == BIT_ACK);

    // ----------------------------------------
    // Strap capture and slave address.
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            strap_wait_r <= 2'h0;
            strap_done_r <= 1'b0;
            SERIAL_MODE <= 1'b0;
        end else begin
            // Wait until the strap synchronisers hold real pin levels.
            strap_wait_r <= {strap_wait_r[0], 1'b1};
            if (strap_wait_r[1] && !strap_done_r) begin
                strap_done_r <= 1'b1;
                SERIAL_MODE <= (oe_s2_r == STRAP_OE_N) && (wr_s2_r == STRAP_WR_N);
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            SLAVE_ADDR <= ADDR_RESET;
        end else if (ADDR_LOAD) begin
            SLAVE_ADDR <= ADDR_NEW;
        end
    end

    // ----------------------------------------
    // Bit engine.
    // ----------------------------------------
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= ST_IDLE;
            bit_r <= BIT_ZERO;
            sh_r <= '0;
            rnw_r <= 1'b0;
            ack_drv_r <= 1'b0;
            rd_drv_r <= 1'b0;
            RX_VALID <= 1'b0;
            RX_DATA <= '0;
        end else begin
            RX_VALID <= 1'b0;
            if (stop_c) begin
                st_r <= ST_IDLE;
                ack_drv_r <= 1'b0;
                rd_drv_r <= 1'b0;
            end else if (start_c) begin
                st_r <= ST_ADDR;
                bit_r <= BIT_ZERO;
                ack_drv_r <= 1'b0;
                rd_drv_r <= 1'b0;
            end else if (scl_rise && st_r != ST_IDLE && st_r != ST_SKIP) begin
                if (at_ack) begin
                    bit_r <= BIT_ZERO;
                    // Host not-acknowledge ends a read.
                    if (st_r == ST_READ && sda_s2_r) begin
                        st_r <= ST_SKIP;
                    end
                end else begin
                    sh_r <= rx_byte;
                    bit_r <= bit_r + 4'h1;
                end
                if (bit_r == BIT_LAST && st_r == ST_ADDR) begin
                    if (!ADDR_CHECK_EN || rx_byte[DATA_W-1:1] == SLAVE_ADDR) begin
                        rnw_r <= rx_byte[0];
                        st_r <= rx_byte[0] ? ST_READ : ST_WRITE;
                    end else begin
                        st_r <= ST_SKIP;
                    end
                end
                if (bit_r == BIT_LAST && st_r == ST_WRITE) begin
                    RX_VALID <= 1'b1;
                    RX_DATA <= rx_byte;
                end
            end else if (scl_fall) begin
                // Drive acknowledge for a full clock period after a byte.
                ack_drv_r <= (bit_r == BIT_ACK) && (st_r == ST_WRITE || st_r == ST_READ)
                             && !(st_r == ST_READ && rnw_r && rd_drv_r);
                rd_drv_r <= (st_r == ST_READ) && !at_ack;
            end
        end
    end

    // ----------------------------------------
    // Read data and request line.
    // ----------------------------------------
    // Reload only after the read bit driver lets go, so the pin never moves while the clock is high.
    assign fifo_pop = fifo_v && !out_has_r && !rd_drv_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            out_r <= '1;
            out_has_r <= 1'b0;
        end else if (fifo_pop) begin
            out_r <= fifo_d;
            out_has_r <= 1'b1;
        end else if (st_r == ST_READ && scl_rise && bit_r == BIT_LAST) begin
            out_has_r <= 1'b0;
        end else if (st_r == ST_READ && scl_fall && bit_r != BIT_ACK && bit_r != BIT_ZERO) begin
            out_r <= {out_r[DATA_W-2:0], 1'b1};
        end
    end

    // The request drops at the last bit's rise only when nothing else is waiting.
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINK.req_oe <= 1'b0;
        end else if (st_r == ST_READ && scl_rise && bit_r == BIT_LAST && !fifo_v) begin
            LINK.req_oe <= 1'b0;
        end else if (st_r == ST_READ && !at_ack && bit_r != BIT_ZERO) begin
            LINK.req_oe <= LINK.req_oe;
        end else begin
            LINK.req_oe <= out_has_r || fifo_v;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINK.sda_dev_o <= 1'b1;
            LINK.sda_dev_oe <= 1'b0;
        end else begin
            LINK.sda_dev_o <= ack_drv_r ? 1'b0 : out_r[DATA_W-1];
            LINK.sda_dev_oe <= ack_drv_r || (rd_drv_r && !out_r[DATA_W-1]);
        end
    end
endmodule : adhp_device

// *** logic/adhp_host.sv ***
`timescale 1ns/1ps
module adhp_host
    import adhp_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Link.
    adhp_if.host LINK,
    // Command.
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire logic CMD_RNW,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    input wire logic [DATA_W-1:0] CMD_DATA,
    // Results.
    output logic RD_VALID,
    output logic [DATA_W-1:0] RD_DATA,
    output logic ACK_ERR,
    output logic REQ_SEEN
);
    typedef enum logic [5:0] {
        H_IDLE = 6'b000001, H_START = 6'b000010, H_BYTE = 6'b000100,
        H_ACK = 6'b001000, H_STOP = 6'b010000, H_DONE = 6'b100000
    } adhp_host_st_t;
    adhp_host_st_t st_r;
    logic [7:0] div_r;
    logic ph_r;
    logic [3:0] bit_r;
    logic [DATA_W-1:0] sh_r;
    logic rnw_r, addr_ph_r;
    logic sda_s1_r, sda_s2_r, req_s1_r, req_s2_r;
    logic tick;

    assign tick = (div_r == HALF_CNT);

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sda_s1_r <= 1'b1; sda_s2_r <= 1'b1; req_s1_r <= 1'b1; req_s2_r <= 1'b1;
            REQ_SEEN <= 1'b0;
            div_r <= '0;
        end else begin
            sda_s1_r <= LINK.serial_ctrl_data_io; sda_s2_r <= sda_s1_r;
            req_s1_r <= LINK.host_data_request_n; req_s2_r <= req_s1_r;
            REQ_SEEN <= !req_s2_r;
            div_r <= tick ? 8'h00 : div_r + 8'h01;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINK.mem_output_enable_strobe_n <= STRAP_OE_N;
            LINK.mem_write_strobe_n <= STRAP_WR_N;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= H_IDLE; ph_r <= 1'b0; bit_r <= BIT_ZERO; sh_r <= '0;
            rnw_r <= 1'b0; addr_ph_r <= 1'b0;
            CMD_READY <= 1'b0; RD_VALID <= 1'b0; RD_DATA <= '0; ACK_ERR <= 1'b0;
            LINK.serial_ctrl_clock <= 1'b1; LINK.sda_host_o <= 1'b1; LINK.sda_host_oe <= 1'b0;
        end else begin
            RD_VALID <= 1'b0;
            CMD_READY <= 1'b0;
            if (tick) begin
                ph_r <= !ph_r;
                case (st_r)
                    H_IDLE: begin
                        if (CMD_VALID) begin
                            rnw_r <= CMD_RNW;
                            sh_r <= {CMD_ADDR, CMD_RNW};
                            addr_ph_r <= 1'b1;
                            LINK.sda_host_oe <= 1'b1; LINK.sda_host_o <= 1'b0;
                            st_r <= H_START; ph_r <= 1'b0;
                        end
                    end
                    H_START: begin
                        LINK.serial_ctrl_clock <= 1'b0;
                        st_r <= H_BYTE; bit_r <= BIT_ZERO; ph_r <= 1'b0;
                    end
                    H_BYTE: begin
                        if (!ph_r) begin
                            LINK.serial_ctrl_clock <= 1'b0;
                            LINK.sda_host_oe <= !(rnw_r && !addr_ph_r) && !sh_r[DATA_W-1];
                            LINK.sda_host_o <= 1'b0;
                        end else begin
                            LINK.serial_ctrl_clock <= 1'b1;
                            sh_r <= {sh_r[DATA_W-2:0], sda_s2_r};
                            bit_r <= bit_r + 4'h1;
                            if (bit_r == BIT_LAST) begin
                                st_r <= H_ACK;
                            end
                        end
                    end
                    H_ACK: begin
                        if (!ph_r) begin
                            LINK.serial_ctrl_clock <= 1'b0;
                            // Acknowledge read bytes while the request is held.
                            LINK.sda_host_oe <= rnw_r && !addr_ph_r && !req_s2_r;
                            LINK.sda_host_o <= 1'b0;
                        end else begin
                            LINK.serial_ctrl_clock <= 1'b1;
                            if (rnw_r && !addr_ph_r) begin
                                RD_VALID <= 1'b1; RD_DATA <= sh_r;
                            end
                            if (!rnw_r && !addr_ph_r) begin
                                ACK_ERR <= sda_s2_r;
                            end
                            addr_ph_r <= 1'b0;
                            bit_r <= BIT_ZERO;
                            if (addr_ph_r ? sda_s2_r : (rnw_r ? LINK.sda_host_oe == 1'b0 : 1'b1))
                                st_r <= H_STOP;
                            else begin
                                st_r <= H_BYTE;
                                if (!rnw_r) sh_r <= CMD_DATA;
                            end
                        end
                    end
                    H_STOP: begin
                        if (!ph_r) begin
                            LINK.serial_ctrl_clock <= 1'b0;
                            LINK.sda_host_oe <= 1'b1; LINK.sda_host_o <= 1'b0;
                        end else begin
                            LINK.serial_ctrl_clock <= 1'b1;
                            st_r <= H_DONE;
                        end
                    end
                    H_DONE: begin
                        LINK.sda_host_oe <= 1'b0;
                        CMD_READY <= 1'b1;
                        st_r <= H_IDLE;
                    end
                    default: st_r <= H_IDLE;
                endcase
            end
        end
    end
endmodule : adhp_host

// *** bench/adhp_checker.sv ***
`timescale 1ns/1ps
// ----
// Link checker.
// ----
module adhp_checker
    import adhp_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RSTN,
    // Link signals.
    input wire logic serial_ctrl_clock,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe,
    input wire logic serial_ctrl_data_io,
    input wire logic req_oe,
    input wire logic host_data_request_n,
    input wire logic mem_output_enable_strobe_n,
    input wire logic mem_write_strobe_n
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    wire logic dev_low = sda_dev_oe && !sda_dev_o;

    property p_req_pin;
        host_data_request_n == !req_oe;
    endproperty
    a_req_pin: assert property (p_req_pin) else $error("request pin level wrong");
    property p_dev_edge;
        (sda_dev_oe && $changed(sda_dev_o)) || $changed(sda_dev_oe) |-> !serial_ctrl_clock;
    endproperty
    a_dev_edge: assert property (p_dev_edge) else $error("device bit moved in high phase");
    property p_bit_stands;
        $rose(dev_low) |-> dev_low[*7];
    endproperty
    a_bit_stands: assert property (p_bit_stands) else $error("driven low bit too short");
    property p_clk_half;
        $changed(serial_ctrl_clock) |=> $stable(serial_ctrl_clock)[*3];
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("serial clock phase too short");
    property p_stop_hold;
        serial_ctrl_clock && $past(serial_ctrl_clock) && $rose(serial_ctrl_data_io)
            |=> serial_ctrl_clock[*3];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("clock moved after stop");
    property p_req_rel_high;
        $fell(req_oe) |-> serial_ctrl_clock;
    endproperty
    a_req_rel_high: assert property (p_req_rel_high) else $error("request freed in low phase");
    property p_req_rel_hold;
        $fell(req_oe) |-> !req_oe[*5];
    endproperty
    a_req_rel_hold: assert property (p_req_rel_hold) else $error("request back too soon");
    property p_req_held;
        $rose(req_oe) |=> req_oe[*8];
    endproperty
    a_req_held: assert property (p_req_held) else $error("request dropped early");
    property p_strap;
        mem_output_enable_strobe_n == STRAP_OE_N && mem_write_strobe_n == STRAP_WR_N;
    endproperty
    a_strap: assert property (p_strap) else $error("strap levels wrong");
    // A high phase lasts eight samples, so nine in a row means the bus is idle.
    property p_dev_idle;
        serial_ctrl_clock[*8] ##1 serial_ctrl_clock |-> !dev_low;
    endproperty
    a_dev_idle: assert property (p_dev_idle) else $error("device holds idle line");
    c_ack: cover property ($rose(dev_low));
    c_req: cover property ($rose(req_oe));
    c_rel: cover property ($fell(req_oe));
endmodule : adhp_checker

// *** bench/adhp_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin check_count++; if ((ac) !== (ex)) begin n_errors++; \
    $display("wrong value %s exp %0h got %0h", nm, ex, ac); end end
// ----
// Bench.
// ----
module adhp_tb;
    import adhp_pkg::*;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic chk_en = 1'b1;
    logic addr_load = 1'b0;
    logic [6:0] addr_new = 7'h00;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic cmd_valid = 1'b0;
    logic cmd_rnw = 1'b0;
    logic [6:0] cmd_addr = 7'h00;
    logic [7:0] cmd_data = 8'h00;
    logic tx_ready, rx_valid, serial_mode, cmd_ready, rd_valid, ack_err, req_seen;
    logic [7:0] rx_data, rd_data;
    logic [6:0] slave_addr;
    logic [7:0] rx_q[$];
    logic [7:0] rd_q[$];
    int n_errors = 0;
    int check_count = 0;

    always #12.5 CLK = ~CLK;

    adhp_if u_adhp_if();
    adhp_device u_adhp_device(.CLK(CLK), .RSTN(RSTN), .LINK(u_adhp_if), .ADDR_CHECK_EN(chk_en),
        .ADDR_LOAD(addr_load), .ADDR_NEW(addr_new), .TX_VALID(tx_valid), .TX_READY(tx_ready),
        .TX_DATA(tx_data), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .SERIAL_MODE(serial_mode), .SLAVE_ADDR(slave_addr));
    adhp_host u_adhp_host(.CLK(CLK), .RSTN(RSTN), .LINK(u_adhp_if), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_RNW(cmd_rnw), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
        .RD_VALID(rd_valid), .RD_DATA(rd_data), .ACK_ERR(ack_err), .REQ_SEEN(req_seen));
    adhp_checker u_adhp_checker(.CLK(CLK), .RSTN(RSTN),
        .serial_ctrl_clock(u_adhp_if.serial_ctrl_clock), .sda_dev_o(u_adhp_if.sda_dev_o),
        .sda_dev_oe(u_adhp_if.sda_dev_oe), .serial_ctrl_data_io(u_adhp_if.serial_ctrl_data_io),
        .req_oe(u_adhp_if.req_oe), .host_data_request_n(u_adhp_if.host_data_request_n),
        .mem_output_enable_strobe_n(u_adhp_if.mem_output_enable_strobe_n),
        .mem_write_strobe_n(u_adhp_if.mem_write_strobe_n));

    always @(posedge CLK) begin
        if (rx_valid === 1'b1) rx_q.push_back(rx_data);
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    end

    task automatic results;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic host_cmd(input logic rnw, input logic [6:0] a, input logic [7:0] d);
        int n = 0;
        @(negedge CLK);
        cmd_valid = 1'b1;
        cmd_rnw = rnw;
        cmd_addr = a;
        cmd_data = d;
        do begin @(negedge CLK); n++; end while (cmd_ready !== 1'b1 && n < 6000);
        cmd_valid = 1'b0;
        if (n >= 6000) begin n_errors++; results(); end
    endtask : host_cmd

    task automatic push(input logic [7:0] d);
        int n = 0;
        @(negedge CLK);
        tx_data = d;
        tx_valid = 1'b1;
        while (tx_ready !== 1'b1 && n < 50) begin @(negedge CLK); n++; end
        @(negedge CLK);
        tx_valid = 1'b0;
        if (n >= 50) begin n_errors++; results(); end
    endtask : push

    task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic hit);
        rx_q.delete();
        host_cmd(1'b0, a, d);
        `CHK("rx_count", hit ? 1 : 0, rx_q.size())
        if (hit && rx_q.size() == 1) `CHK("rx_data", d, rx_q[0])
    endtask : wr

    task automatic load_addr(input logic [6:0] a);
        @(negedge CLK);
        addr_new = a;
        addr_load = 1'b1;
        @(negedge CLK);
        addr_load = 1'b0;
        @(negedge CLK);
        `CHK("slave_addr", a, slave_addr)
    endtask : load_addr

    task automatic read_all(input int cnt, input logic [7:0] base);
        int n = 0;
        while (u_adhp_if.host_data_request_n !== 1'b0 && n < 200) begin @(negedge CLK); n++; end
        `CHK("request_low", 1'b0, u_adhp_if.host_data_request_n)
        if (n >= 200) results();
        repeat (8) @(negedge CLK);
        `CHK("req_seen", 1'b1, req_seen)
        rd_q.delete();
        host_cmd(1'b1, 7'h33, 8'h00);
        `CHK("miss_count", 0, rd_q.size())
        `CHK("request_held", 1'b0, u_adhp_if.host_data_request_n)
        host_cmd(1'b1, 7'h00, 8'h00);
        `CHK("rd_count", cnt, rd_q.size())
        for (int i = 0; i < rd_q.size(); i++) `CHK("rd_data", 8'(base + i), rd_q[i])
        `CHK("request_free", 1'b1, u_adhp_if.host_data_request_n)
    endtask : read_all

    task automatic t_reset;
        `CHK("slave_addr", 7'h00, slave_addr)
        `CHK("serial_mode", 1'b1, serial_mode)
        `CHK("request", 1'b1, u_adhp_if.host_data_request_n)
        `CHK("data_line", 1'b1, u_adhp_if.serial_ctrl_data_io)
        $display("test reset done");
    endtask : t_reset

    task automatic t_write;
        wr(7'h00, 8'ha5, 1'b1);
        `CHK("ack_err", 1'b0, ack_err)
        wr(7'h12, 8'h5a, 1'b0);
        wr(7'h00, 8'h00, 1'b1);
        $display("test write done");
    endtask : t_write

    task automatic t_addr;
        load_addr(7'h5a);
        wr(7'h5a, 8'h3c, 1'b1);
        wr(7'h00, 8'h66, 1'b0);
        chk_en = 1'b0;
        wr(7'h11, 8'hc3, 1'b1);
        chk_en = 1'b1;
        load_addr(7'h00);
        $display("test address done");
    endtask : t_addr

    task automatic t_read;
        for (int i = 0; i < 3; i++) push(8'(8'h81 + i));
        read_all(3, 8'h81);
        $display("test read done");
    endtask : t_read

    task automatic t_fill;
        int n = 0;
        while (n < 20) begin
            @(negedge CLK);
            if (tx_ready !== 1'b1) break;
            push(8'(8'h10 + n));
            n++;
        end
        `CHK("fill", FIFO_DEPTH + 1, n)
        read_all(n, 8'h10);
        $display("test fill done");
    endtask : t_fill

    initial begin
        repeat (20) @(negedge CLK);
        RSTN = 1'b1;
        repeat (5) @(negedge CLK);
        t_reset();
        t_write();
        t_addr();
        t_read();
        t_fill();
        results();
    end
endmodule : adhp_tb
